//--- verilog/pirq_pkg.sv
// constants shared by the peripheral request flag block
// assumes a single system clock and byte-wide register port
// Behaviour
// - timer-4 event sets bit 0, sticky
// - flags set regardless of enable bits
// - register c at 0x8F, eight flags
// - port-1 collision sets bit 7
// - port-1 event sets bit 6
// - rx2 flag mirrors receive buffer non-empty
// - tx2 flag mirrors transmit buffer empty
// - rx1 flag mirrors receive buffer non-empty
// - tx1 flag mirrors transmit buffer empty
// - tx flags ignore shift-out completion
// - logic cells 4/3 set bits 1/0
// - register d at 0x90, six flags
// - zero-cross sets bit 5
// - adc threshold sets bit 4
// - adc done sets bit 3
// - comparator 1 sets bit 2
// - port-2 collision sets bit 1
// - port-2 event sets bit 0
package pirq_pkg;
  localparam logic [7:0] PIRQ_OFF_FLAGS_B = 8'h8E;
  localparam logic [7:0] PIRQ_OFF_FLAGS_C = 8'h8F;
  localparam logic [7:0] PIRQ_OFF_FLAGS_D = 8'h90;
  localparam logic [7:0] PIRQ_OFF_IRQ_STAT = 8'hA0;
  localparam logic [7:0] PIRQ_OFF_IRQ_MASK = 8'hA1;
  localparam logic [7:0] PIRQ_RST_FLAGS = 8'h00;
  localparam logic [7:0] PIRQ_RW_MASK_C = 8'hC3;
  localparam logic [7:0] PIRQ_RW_MASK_D = 8'h3F;
  localparam logic [7:0] PIRQ_RW_MASK_B = 8'h01;
  localparam int PIRQ_BIT_TIMER4 = 0;
  localparam int PIRQ_BIT_TX1 = 2;
  localparam int PIRQ_BIT_RX1 = 3;
  localparam int PIRQ_BIT_TX2 = 4;
  localparam int PIRQ_BIT_RX2 = 5;
endpackage

//--- verilog/pirq_sync.sv
// two-flop synchroniser for a bus of pin-level inputs
// assumes inputs may come from outside the clock domain
`timescale 1ns/1ns
module pirq_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

//--- verilog/pirq_flag.sv
// one sticky hardware-set, software-writable flag bit
// assumes set and write are single-cycle on the system clock
`timescale 1ns/1ns
module pirq_flag (
  input wire logic clk,
  input wire logic resetn,
  input wire logic set_i,
  input wire logic wr_i,
  input wire logic wdata_i,
  output logic flag_o
);
  logic flag_d;
  assign flag_d = set_i | (wr_i ? wdata_i : flag_o);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= flag_d;
    end
  end
endmodule

//--- verilog/pirq_top.sv
// peripheral request flag registers c and d, plus timer-4 flag
// assumes event inputs are one-cycle pulses on CLK, buffer levels too
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module pirq_top
  import pirq_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic TIMER4_EVT,
  input wire logic SPORT1_COLL_EVT,
  input wire logic SPORT1_EVT,
  input wire logic LCELL4_EVT,
  input wire logic LCELL3_EVT,
  input wire logic ZERO_CROSS_EVT,
  input wire logic ADC_THRESH_EVT,
  input wire logic ADC_DONE_EVT,
  input wire logic COMP1_EVT,
  input wire logic SPORT2_COLL_EVT,
  input wire logic SPORT2_EVT,
  input wire logic RX1_NOT_EMPTY,
  input wire logic TX1_BUF_EMPTY,
  input wire logic RX2_NOT_EMPTY,
  input wire logic TX2_BUF_EMPTY,
  input wire logic TX1_SHIFT_EMPTY,
  input wire logic TX2_SHIFT_EMPTY,
  output logic IRQ
);
  // ****************************************
  // decode
  // ****************************************
  // register offsets
  logic wr_b, wr_c, wr_d, wr_mask;
  logic rd_stat;
  assign wr_b = WR && (ADDR == PIRQ_OFF_FLAGS_B);
  assign wr_c = WR && (ADDR == PIRQ_OFF_FLAGS_C);
  assign wr_d = WR && (ADDR == PIRQ_OFF_FLAGS_D);
  assign wr_mask = WR && (ADDR == PIRQ_OFF_IRQ_MASK);
  assign rd_stat = RD && (ADDR == PIRQ_OFF_IRQ_STAT);

  // ****************************************
  // hardware set sources
  // ****************************************
  logic [7:0] set_b, set_c, set_d;
  logic [7:0] flags_b, flags_c, flags_d;
  assign set_b = {7'h00, TIMER4_EVT};
  assign set_c = {SPORT1_COLL_EVT, SPORT1_EVT, 4'h0, LCELL4_EVT, LCELL3_EVT};
  assign set_d = {2'b00, ZERO_CROSS_EVT, ADC_THRESH_EVT, ADC_DONE_EVT,
                  COMP1_EVT, SPORT2_COLL_EVT, SPORT2_EVT};

  // ****************************************
  // sticky flags
  // ****************************************
  // no enable gating on set
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if (PIRQ_RW_MASK_B[gi]) begin : g_b
        pirq_flag u_b (.clk(CLK), .resetn(RESETN), .set_i(set_b[gi]), .wr_i(wr_b),
                       .wdata_i(WDATA[gi]), .flag_o(flags_b[gi]));
      end else begin : g_nb
        assign flags_b[gi] = 1'b0;
      end
      if (PIRQ_RW_MASK_C[gi]) begin : g_c
        pirq_flag u_c (.clk(CLK), .resetn(RESETN), .set_i(set_c[gi]), .wr_i(wr_c),
                       .wdata_i(WDATA[gi]), .flag_o(flags_c[gi]));
      end
      if (PIRQ_RW_MASK_D[gi]) begin : g_d
        pirq_flag u_d (.clk(CLK), .resetn(RESETN), .set_i(set_d[gi]), .wr_i(wr_d),
                       .wdata_i(WDATA[gi]), .flag_o(flags_d[gi]));
      end else begin : g_nd
        assign flags_d[gi] = 1'b0;
      end
    end
  endgenerate

  // ****************************************
  // serial buffer mirrors
  // ****************************************
  // shift-empty levels feed only a check: tx flags must not follow them
  logic [1:0] shift_empty;
  pirq_sync #(
    .WIDTH(2)
  ) u_pirq_sync (
    .clk(CLK),
    .resetn(RESETN),
    .din({TX2_SHIFT_EMPTY, TX1_SHIFT_EMPTY}),
    .dout(shift_empty)
  );
  logic [3:0] buf_lvl;
  assign buf_lvl = {RX2_NOT_EMPTY, TX2_BUF_EMPTY, RX1_NOT_EMPTY, TX1_BUF_EMPTY};
  assign flags_c[PIRQ_BIT_TX1] = buf_lvl[0];
  assign flags_c[PIRQ_BIT_RX1] = buf_lvl[1];
  assign flags_c[PIRQ_BIT_TX2] = buf_lvl[2];
  assign flags_c[PIRQ_BIT_RX2] = buf_lvl[3];

  // ****************************************
  // interrupt status and mask
  // ****************************************
  // status bit0 timer4, 1 reg c any, 2 reg d any; sticky until read
  logic [2:0] stat_q, stat_d, evt;
  logic [2:0] mask_q;
  assign evt = {|set_d, |set_c, set_b[0]};
  // read clears, a same-cycle event still lands
  assign stat_d = (rd_stat ? 3'h0 : stat_q) | evt;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stat_q <= PIRQ_RST_FLAGS[2:0];
      mask_q <= PIRQ_RST_FLAGS[2:0];
    end else begin
      stat_q <= stat_d;
      if (wr_mask) mask_q <= WDATA[2:0];
    end
  end
  assign IRQ = |(stat_q & mask_q);

  // ****************************************
  // read port
  // ****************************************
  logic [7:0] rsel;
  assign rsel = (ADDR == PIRQ_OFF_FLAGS_B) ? flags_b :
                (ADDR == PIRQ_OFF_FLAGS_C) ? flags_c :
                (ADDR == PIRQ_OFF_FLAGS_D) ? flags_d :
                (ADDR == PIRQ_OFF_IRQ_STAT) ? {5'h00, stat_q} :
                (ADDR == PIRQ_OFF_IRQ_MASK) ? {5'h00, mask_q} : 8'h00;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= PIRQ_RST_FLAGS;
    end else begin
      RDATA <= RD ? rsel : 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  timer4_sets_a: assert property (@(posedge CLK) disable iff (!RESETN)
    TIMER4_EVT |=> flags_b[PIRQ_BIT_TIMER4]) else $error("timer4 flag not set");
  sticky_c_a: assert property (@(posedge CLK) disable iff (!RESETN)
    flags_c[7] && !wr_c |=> flags_c[7]) else $error("collision flag lost");
  port1_evt_a: assert property (@(posedge CLK) disable iff (!RESETN)
    SPORT1_EVT |=> flags_c[6]) else $error("port1 flag not set");
  rx2_mirror_a: assert property (@(posedge CLK) disable iff (!RESETN)
    flags_c[PIRQ_BIT_RX2] == RX2_NOT_EMPTY) else $error("rx2 mirror wrong");
  tx1_mirror_a: assert property (@(posedge CLK) disable iff (!RESETN)
    flags_c[PIRQ_BIT_TX1] == TX1_BUF_EMPTY) else $error("tx1 mirror wrong");
  d_upper_zero_a: assert property (@(posedge CLK) disable iff (!RESETN)
    flags_d[7:6] == 2'b00) else $error("unimplemented bits set");
  zero_cross_a: assert property (@(posedge CLK) disable iff (!RESETN)
    ZERO_CROSS_EVT |=> flags_d[5]) else $error("zero cross flag not set");
  set_wins_a: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_d && !WDATA[0] && SPORT2_EVT |=> flags_d[0]) else $error("set lost to clear");
  irq_level_a: assert property (@(posedge CLK) disable iff (!RESETN)
    ADC_DONE_EVT && mask_q[2] && !wr_mask |=> IRQ) else $error("irq missing");

  // ****************************************
  // flag and status checks
  // ****************************************
  timer4_sticky_a: assert property (@(posedge CLK) disable iff (!RESETN)
    flags_b[PIRQ_BIT_TIMER4] && !wr_b |=> flags_b[PIRQ_BIT_TIMER4])
    else $error("timer4 flag lost");
  event_status_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (|set_c) |=> stat_q[1])
    else $error("status bit not set");
  status_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
    rd_stat && !(|evt) |=> stat_q == 3'h0)
    else $error("status not cleared by read");
  irq_masked_a: assert property (@(posedge CLK) disable iff (!RESETN)
    mask_q == 3'h0 |-> !IRQ)
    else $error("irq while all masked");
  c_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_c && !(|set_c) |=> (flags_c & PIRQ_RW_MASK_C) == ($past(WDATA) & PIRQ_RW_MASK_C))
    else $error("register c write not stored");
  rdata_idle_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !RD |=> RDATA == 8'h00)
    else $error("read data without strobe");
  port1_coll_a: assert property (@(posedge CLK) disable iff (!RESETN)
    SPORT1_COLL_EVT |=> flags_c[7])
    else $error("port1 collision flag not set");
  port1_sticky_a: assert property (@(posedge CLK) disable iff (!RESETN)
    flags_c[6] && !wr_c |=> flags_c[6])
    else $error("port1 event flag lost");
  tx2_mirror_a: assert property (@(posedge CLK) disable iff (!RESETN)
    flags_c[PIRQ_BIT_TX2] == TX2_BUF_EMPTY)
    else $error("tx2 mirror wrong");
  rx1_mirror_a: assert property (@(posedge CLK) disable iff (!RESETN)
    flags_c[PIRQ_BIT_RX1] == RX1_NOT_EMPTY)
    else $error("rx1 mirror wrong");
  shift_ignored_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (|shift_empty) |-> flags_c[PIRQ_BIT_TX1] == TX1_BUF_EMPTY &&
    flags_c[PIRQ_BIT_TX2] == TX2_BUF_EMPTY)
    else $error("tx flag follows shift-out");
  cell4_sets_a: assert property (@(posedge CLK) disable iff (!RESETN)
    LCELL4_EVT |=> flags_c[1])
    else $error("logic cell 4 flag not set");
  cell3_sets_a: assert property (@(posedge CLK) disable iff (!RESETN)
    LCELL3_EVT |=> flags_c[0])
    else $error("logic cell 3 flag not set");
  d_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_d && !(|set_d) |=> flags_d == ($past(WDATA) & PIRQ_RW_MASK_D))
    else $error("register d write not stored");
  zero_sticky_a: assert property (@(posedge CLK) disable iff (!RESETN)
    flags_d[5] && !wr_d |=> flags_d[5])
    else $error("zero cross flag lost");
  adc_thresh_a: assert property (@(posedge CLK) disable iff (!RESETN)
    ADC_THRESH_EVT |=> flags_d[4])
    else $error("adc threshold flag not set");
  adc_done_a: assert property (@(posedge CLK) disable iff (!RESETN)
    ADC_DONE_EVT |=> flags_d[3])
    else $error("adc done flag not set");
  comp1_sets_a: assert property (@(posedge CLK) disable iff (!RESETN)
    COMP1_EVT |=> flags_d[2])
    else $error("comparator flag not set");
  port2_coll_a: assert property (@(posedge CLK) disable iff (!RESETN)
    SPORT2_COLL_EVT |=> flags_d[1])
    else $error("port2 collision flag not set");
  port2_evt_a: assert property (@(posedge CLK) disable iff (!RESETN)
    SPORT2_EVT |=> flags_d[0])
    else $error("port2 event flag not set");
endmodule

//--- testbench/pirq_periph.sv
// model of the peripherals and serial channels beside the flag block
// assumes the bench commands it on CLK; events leave as one-cycle pulses
`timescale 1ns/1ns
module pirq_periph (
  input wire logic clk,
  input wire logic [10:0] fire,
  input wire logic [5:0] lvl,
  output logic [10:0] evt = 11'h000,
  output logic [5:0] buf_lvl = 6'h00
);
  // raw events, buffer levels
  // a real peripheral pulses once, so the pulse must be latched downstream
  always @(posedge clk) begin
    evt <= fire;
    buf_lvl <= lvl;
  end
endmodule

//--- testbench/tb.sv
// self-checking bench for the peripheral request flag block
// assumes the designer's package and modules are compiled first
`timescale 1ns/1ns
module tb;
  import pirq_pkg::*;
  logic CLK = 0, RESETN = 0, WR = 0, RD = 0, rd_d = 0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, w, a, RDATA;
  logic [10:0] fire = 11'h000, evt;
  logic [5:0] lvl = 6'h00, bl;
  logic IRQ;
  int bad_count = 0, checks_done = 0;
  logic [7:0] expq[$];
  byte bt[11] = '{0, 0, 1, 6, 7, 0, 1, 2, 3, 4, 5};
  logic [7:0] ra[6] = '{8'h8E, 8'h8F, 8'h90, 8'hA0, 8'hA1, 8'h55};
  pirq_periph u_pirq_periph (.clk(CLK), .fire(fire), .lvl(lvl), .evt(evt), .buf_lvl(bl));
  pirq_top u_pirq_top (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TIMER4_EVT(evt[0]), .LCELL3_EVT(evt[1]), .LCELL4_EVT(evt[2]),
    .SPORT1_EVT(evt[3]), .SPORT1_COLL_EVT(evt[4]), .SPORT2_EVT(evt[5]),
    .SPORT2_COLL_EVT(evt[6]), .COMP1_EVT(evt[7]), .ADC_DONE_EVT(evt[8]),
    .ADC_THRESH_EVT(evt[9]), .ZERO_CROSS_EVT(evt[10]), .TX1_BUF_EMPTY(bl[0]),
    .RX1_NOT_EMPTY(bl[1]), .TX2_BUF_EMPTY(bl[2]), .RX2_NOT_EMPTY(bl[3]),
    .TX1_SHIFT_EMPTY(bl[4]), .TX2_SHIFT_EMPTY(bl[5]), .IRQ(IRQ));
  // ****************************************
  // bus tasks and checking
  // ****************************************
  initial forever #4 CLK = ~CLK;
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_irq(logic e, logic g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value irq expected %b seen %b", e, g);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= ad;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= ad;
    expq.push_back(e);
    @(posedge CLK);
    RD <= 1'b0;
  endtask
  task automatic ev(int i);
    @(posedge CLK);
    fire <= 11'h001 << i;
    @(posedge CLK);
    fire <= 11'h000;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge CLK) rd_d <= RD;
  always @(negedge CLK) begin
    if (rd_d) chk("rdata", expq.pop_front(), RDATA);
  end
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(38765));
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    for (int k = 0; k < 6; k++) rd(ra[k], 8'h00);
    for (int i = 0; i < 11; i++) begin
      a = (i == 0) ? PIRQ_OFF_FLAGS_B : ((i < 5) ? PIRQ_OFF_FLAGS_C : PIRQ_OFF_FLAGS_D);
      ev(i);
      rd(a, 8'h01 << bt[i]);
      wr(a, 8'h00);
      rd(a, 8'h00);
    end
    rd(PIRQ_OFF_IRQ_STAT, 8'h07);
    rd(PIRQ_OFF_IRQ_STAT, 8'h00);
    wr(PIRQ_OFF_IRQ_MASK, 8'h07);
    rd(PIRQ_OFF_IRQ_MASK, 8'h07);
    ev(1);
    repeat (2) @(negedge CLK);
    chk_irq(1'b1, IRQ);
    wr(PIRQ_OFF_IRQ_MASK, 8'h05);
    @(negedge CLK);
    chk_irq(1'b0, IRQ);
    rd(PIRQ_OFF_IRQ_STAT, 8'h02);
    wr(PIRQ_OFF_IRQ_MASK, 8'h07);
    @(negedge CLK);
    chk_irq(1'b0, IRQ);
    // buffer mirrors ignore writes and the shift-empty levels
    for (int k = 0; k < 16; k++) begin
      lvl <= {2'($urandom_range(3, 0)), 4'(k)};
      w = 8'($urandom);
      wr(PIRQ_OFF_FLAGS_C, w);
      rd(PIRQ_OFF_FLAGS_C, (w & PIRQ_RW_MASK_C) | 8'(k << 2));
      wr(PIRQ_OFF_FLAGS_D, w);
      rd(PIRQ_OFF_FLAGS_D, w & PIRQ_RW_MASK_D);
      wr(PIRQ_OFF_FLAGS_B, w);
      rd(PIRQ_OFF_FLAGS_B, w & PIRQ_RW_MASK_B);
    end
    // set event and software clear land on the same edge
    @(posedge CLK);
    fire <= 11'h020;
    @(posedge CLK);
    fire <= 11'h000;
    WR <= 1'b1;
    ADDR <= PIRQ_OFF_FLAGS_D;
    WDATA <= 8'h00;
    @(posedge CLK);
    WR <= 1'b0;
    rd(PIRQ_OFF_FLAGS_D, 8'h01);
    // mid-run reset clears flags, status and mask
    lvl <= 6'h00;
    ev(0);
    ev(10);
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    for (int k = 0; k < 6; k++) rd(ra[k], 8'h00);
    repeat (4) @(posedge CLK);
    finish_test();
  end
  initial begin
    #40000;
    bad_count++;
    finish_test();
  end
endmodule
